//--- src/flood_retry_ctrl.sv
// error containment for one link node: flood, routing, retry mode, stomping
// assumes pins arrive unsynchronised; crc and packet framing come from neighbours
`timescale 1ns/10ps
`default_nettype none

// Function
// - error flood drives all lanes to ones
// - received flood after init is relayed everywhere, except upward on a bridge without both enables
// - flooding continues until reset
// - no crc generate/check during sync
// - every flood participant sets chain-fail flag
// - warm reset ends flood, flags persist
// - initiating needs serr enable, sets signalled flag
// - bridge sets detected flag for foreign flood
// - upward relay needs both bridge enables
// - unrelayed secondary flood becomes fatal/nonfatal
// - in-chain relay needs no enable
// - bridge always floods primary to secondary
// - log with enable gives that notification
// - flood routing only for four error kinds
// - warm reset enters/leaves retry per enable
// - retry mode checks crc, drops, replays
// - retry mode disables periodic crc window
// - exhausted retries declare unrecoverable error for attempt limits up to 7
// - stomp sends inverted correct crc
// - speculation only to retry links, not info
// - stomped packet dropped, credits returned
// - four consecutive syncs before flood acts
module flood_retry_ctrl
	import flood_retry_pkg::*;
(
	// clock and resets
	input  wire logic                        i_ref_clk,
	input  wire logic                        i_rst_b,
	input  wire logic                        i_warm_rst,
	// wishbone slave
	input  wire flood_retry_pkg::wb_req_t    i_wb,
	output logic                             o_wb_ack,
	output logic [31:0]                      o_wb_dat,
	// link pins, primary and secondary
	input  wire flood_retry_pkg::lane_word_t i_pri_rx,
	input  wire flood_retry_pkg::lane_word_t i_sec_rx,
	input  wire flood_retry_pkg::lane_word_t i_pri_tx_data,
	input  wire flood_retry_pkg::lane_word_t i_sec_tx_data,
	output flood_retry_pkg::lane_word_t      o_pri_tx,
	output flood_retry_pkg::lane_word_t      o_sec_tx,
	// neighbour events, same clock
	input  wire logic                        i_init_done,
	input  wire flood_retry_pkg::err_log_t   i_err_set,
	input  wire logic                        i_internal_err,
	input  wire logic                        i_retry_fail,
	input  wire logic                        i_retry_ok,
	input  wire logic                        i_pkt_crc_bad,
	input  wire logic                        i_pkt_stomped,
	input  wire logic                        i_pkt_is_info,
	input  wire logic                        i_fwd_spec_bad,
	input  wire logic [31:0]                 i_fwd_crc,
	// outcomes
	output logic                             o_crc_gen_en,
	output logic                             o_crc_chk_en,
	output logic                             o_periodic_crc_en,
	output logic                             o_retry_mode,
	output logic                             o_retry_start,
	output logic                             o_pkt_drop,
	output logic                             o_credit_return,
	output logic                             o_spec_allowed,
	output logic [31:0]                      o_fwd_crc,
	output logic                             o_fatal,
	output logic                             o_nonfatal
);
	import flood_retry_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		lane_word_t  pri_s1, pri_s2, sec_s1, sec_s2;
		logic [2:0]  pri_run, sec_run;
		link_state_t mode;
		logic        flood_pri, flood_sec;
		logic        crc_chk_off;
		err_log_t    log;
		logic        chain_fail, sig_serr, det_serr, unrecov;
		logic [3:0]  retries;
		logic [31:0] ctrl, route;
		logic        ack;
		logic [31:0] rdat;
		logic        fatal, nonfatal, retry_start, drop, credit;
		logic [31:0] fwd_crc;
	} state_t;

	state_t st_r, st_nxt;

	// one enable bit of an error class: 2 flood, 1 fatal, 0 nonfatal
	function automatic logic route_of(input logic [31:0] r, input int base, input int k);
		route_of = r[base+k];
	endfunction

	logic pri_sync, sec_sync, pri_flood_seen, sec_flood_seen, wb_hit, err_flood;
	logic err_fatal, err_nonfatal, serr_en, bridge_en, is_bridge, init_flood, up_relay;
	logic [3:0] retry_max;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	// sync word is every lane high; only second stage is looked at
	assign pri_sync = &{st_r.pri_s2.data, st_r.pri_s2.ctl};
	assign sec_sync = &{st_r.sec_s2.data, st_r.sec_s2.ctl};
	assign pri_flood_seen = i_init_done && (st_r.pri_run >= SYNC_RUN_MIN);
	assign sec_flood_seen = i_init_done && (st_r.sec_run >= SYNC_RUN_MIN);
	assign serr_en   = st_r.ctrl[C_SERR_EN];
	assign bridge_en = st_r.ctrl[C_BRIDGE_SERR];
	assign is_bridge = st_r.ctrl[C_IS_BRIDGE];
	assign retry_max = st_r.ctrl[C_RETRY_MAX_LO +: 4];
	assign wb_hit    = i_wb.cyc && i_wb.stb && !st_r.ack;

	// routing: flood only for protocol, overflow, crc, unrecoverable retry (on the crc enable)
	always_comb begin
		err_flood    = 1'b0;
		err_fatal    = 1'b0;
		err_nonfatal = 1'b0;
		err_flood = (st_r.log.protocol_error_log && route_of(st_r.route, R_PROT, 2))
			|| (st_r.log.overflow_error_log && route_of(st_r.route, R_OVF, 2))
			|| ((|st_r.log.lane_crc_error_log) && route_of(st_r.route, R_CRC, 2))
			|| (st_r.unrecov && route_of(st_r.route, R_CRC, 2));
		err_fatal = (st_r.log.protocol_error_log && route_of(st_r.route, R_PROT, 1))
			|| (st_r.log.overflow_error_log && route_of(st_r.route, R_OVF, 1))
			|| (st_r.log.end_chain_error_log && route_of(st_r.route, R_EOC, 1))
			|| (st_r.log.response_error_log && route_of(st_r.route, R_RESP, 1))
			|| ((|st_r.log.lane_crc_error_log || st_r.unrecov) && route_of(st_r.route, R_CRC, 1))
			|| (st_r.det_serr && route_of(st_r.route, R_SERR, 1));
		err_nonfatal = (st_r.log.protocol_error_log && route_of(st_r.route, R_PROT, 0))
			|| (st_r.log.overflow_error_log && route_of(st_r.route, R_OVF, 0))
			|| (st_r.log.end_chain_error_log && route_of(st_r.route, R_EOC, 0))
			|| (st_r.log.response_error_log && route_of(st_r.route, R_RESP, 0))
			|| ((|st_r.log.lane_crc_error_log || st_r.unrecov) && route_of(st_r.route, R_CRC, 0))
			|| (st_r.det_serr && route_of(st_r.route, R_SERR, 0));
	end

	// a local flood needs the command-register enable; bridge upward needs both
	assign init_flood = serr_en && err_flood;
	assign up_relay   = is_bridge ? (sec_flood_seen && bridge_en && serr_en) : sec_flood_seen;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.pri_s1 = i_pri_rx;
		st_nxt.pri_s2 = st_r.pri_s1;
		st_nxt.sec_s1 = i_sec_rx;
		st_nxt.sec_s2 = st_r.sec_s1;
		st_nxt.retry_start = 1'b0;
		st_nxt.drop = 1'b0;
		st_nxt.credit = 1'b0;
		// count consecutive sync words, saturating
		st_nxt.pri_run = !pri_sync ? 3'h0 : (st_r.pri_run == SYNC_RUN_MIN ? st_r.pri_run
			: st_r.pri_run + 3'h1);
		st_nxt.sec_run = !sec_sync ? 3'h0 : (st_r.sec_run == SYNC_RUN_MIN ? st_r.sec_run
			: st_r.sec_run + 3'h1);
		// error logs are sticky; hardware set wins
		st_nxt.log = st_r.log | i_err_set;
		// flood latches: sticky until reset
		if (pri_flood_seen || init_flood) begin
			st_nxt.flood_pri = 1'b1;
			st_nxt.flood_sec = 1'b1;
		end
		if (sec_flood_seen) begin
			st_nxt.flood_sec = 1'b1;
		end
		if (up_relay) begin
			st_nxt.flood_pri = 1'b1;
		end
		if (is_bridge && i_internal_err) begin
			st_nxt.flood_sec = 1'b1;
		end
		if (init_flood) begin
			st_nxt.sig_serr = 1'b1;
		end
		if (is_bridge && sec_flood_seen && !st_r.flood_sec) begin
			st_nxt.det_serr = 1'b1;
		end
		if (st_nxt.flood_pri || st_nxt.flood_sec) begin
			st_nxt.chain_fail = 1'b1;
		end
		if (pri_flood_seen || sec_flood_seen) begin
			st_nxt.crc_chk_off = 1'b1;
		end
		// flood state overrides mode
		if (st_nxt.flood_pri || st_nxt.flood_sec) begin
			st_nxt.mode = LS_FLOOD;
		end
		// retry handling: receiver crc failure drops and starts a retry
		if (st_r.mode == LS_RETRY) begin
			if (i_pkt_stomped) begin
				st_nxt.drop = 1'b1;
				st_nxt.credit = 1'b1;
			end else if (i_pkt_crc_bad) begin
				st_nxt.drop = 1'b1;
				st_nxt.retry_start = 1'b1;
			end
			if (i_retry_ok) begin
				st_nxt.retries = 4'h0;
			end else if ((i_pkt_crc_bad && !i_pkt_stomped) || i_retry_fail) begin
				if (st_r.retries != RETRY_CAP) begin
					st_nxt.retries = st_r.retries + 4'h1;
					if (st_r.retries + 4'h1 > retry_max) begin
						st_nxt.unrecov = 1'b1;
					end
				end
			end
		end
		// stomp marks the forwarded crc; info packets are never stomped
		st_nxt.fwd_crc = (i_fwd_spec_bad && !i_pkt_is_info && st_r.mode == LS_RETRY)
			? ~i_fwd_crc : i_fwd_crc;
		st_nxt.fatal = err_fatal;
		st_nxt.nonfatal = err_nonfatal;
		// wishbone: one-cycle ack, writes at the acked edge
		st_nxt.ack = wb_hit;
		st_nxt.rdat = WB_UNMAPPED;
		if (wb_hit) begin
			case (i_wb.adr)
				WB_ADDR_CTRL: begin
					st_nxt.rdat = st_r.ctrl;
					if (i_wb.we) begin
						for (int b = 0; b < 4; b++) begin
							if (i_wb.sel[b]) st_nxt.ctrl[b*8 +: 8] = i_wb.dat[b*8 +: 8];
						end
					end
				end
				WB_ADDR_ROUTE: begin
					st_nxt.rdat = st_r.route;
					if (i_wb.we) begin
						for (int b = 0; b < 4; b++) begin
							if (i_wb.sel[b]) st_nxt.route[b*8 +: 8] = i_wb.dat[b*8 +: 8];
						end
					end
				end
				WB_ADDR_STATUS: begin
					st_nxt.rdat = {19'h0, st_r.retries, st_r.mode, st_r.unrecov, st_r.det_serr,
						st_r.sig_serr, st_r.chain_fail, st_r.flood_sec, st_r.flood_pri};
				end
				WB_ADDR_EVENT: begin
					st_nxt.rdat = {23'h0, st_r.log};
					// write one to clear; a same-cycle set still wins
					if (i_wb.we && i_wb.sel[0]) begin
						st_nxt.log[7:0] = (st_r.log[7:0] & ~i_wb.dat[7:0]) | i_err_set[7:0];
					end
					if (i_wb.we && i_wb.sel[1]) begin
						st_nxt.log.protocol_error_log = (st_r.log.protocol_error_log
							& ~i_wb.dat[8]) | i_err_set.protocol_error_log;
					end
				end
				default: st_nxt.rdat = WB_UNMAPPED;
			endcase
		end
		// warm reset: flood ends, retry mode follows the enable, flags persist
		if (i_warm_rst) begin
			st_nxt.flood_pri = 1'b0;
			st_nxt.flood_sec = 1'b0;
			st_nxt.crc_chk_off = 1'b0;
			st_nxt.retries = 4'h0;
			st_nxt.mode = st_r.ctrl[C_RETRY_EN] ? LS_RETRY : LS_NORMAL;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r <= '0;
			st_r.mode <= LS_NORMAL;
			st_r.ctrl <= CTRL_RST;
			st_r.route <= ROUTE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// flooding lanes are all ones; crc generation stops while either side floods
	assign o_pri_tx = st_r.flood_pri ? '1 : i_pri_tx_data;
	assign o_sec_tx = st_r.flood_sec ? '1 : i_sec_tx_data;
	assign o_crc_gen_en = !(st_r.flood_pri || st_r.flood_sec);
	assign o_crc_chk_en = !st_r.crc_chk_off;
	assign o_periodic_crc_en = (st_r.mode == LS_NORMAL);
	assign o_retry_mode = (st_r.mode == LS_RETRY);
	assign o_spec_allowed = (st_r.mode == LS_RETRY);
	assign o_retry_start = st_r.retry_start;
	assign o_pkt_drop = st_r.drop;
	assign o_credit_return = st_r.credit;
	assign o_fwd_crc = st_r.fwd_crc;
	assign o_fatal = st_r.fatal;
	assign o_nonfatal = st_r.nonfatal;
	assign o_wb_ack = st_r.ack;
	assign o_wb_dat = st_r.rdat;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_flood_holds: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		st_r.flood_pri && !i_warm_rst |=> st_r.flood_pri) else $error("flood dropped");
	a_flood_ones: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		st_r.flood_sec |-> o_sec_tx == '1) else $error("flood lanes not ones");
	a_chain_fail: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		$rose(st_r.flood_pri) |-> st_r.chain_fail) else $error("chain fail missing");
	a_crc_gen_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		st_r.flood_pri |-> !o_crc_gen_en) else $error("crc generated in flood");
	a_sync_run: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		$rose(st_r.flood_pri) && !$past(init_flood) && !$past(up_relay)
		|-> $past(st_r.pri_run) == SYNC_RUN_MIN) else $error("flood without four syncs");
	a_serr_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		$rose(st_r.sig_serr) |-> $past(serr_en)) else $error("signalled without enable");
	a_retry_entry: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		i_warm_rst && st_r.ctrl[C_RETRY_EN] |=> o_retry_mode) else $error("no retry entry");
	a_stomp_credit: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		o_retry_mode && i_pkt_stomped && !i_warm_rst |=> o_credit_return && !o_retry_start)
		else $error("stomped packet mishandled");
	a_flags_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
		i_warm_rst && st_r.chain_fail |=> st_r.chain_fail) else $error("flag lost");
endmodule

`default_nettype wire

//--- src/flood_retry_pkg.sv
// package for the link error flood / retry control block
// assumes one 100 MHz core clock and a 4-lane link sampled from pins
package flood_retry_pkg;
	localparam int          LANES          = 4;
	localparam int          CLK_MHZ        = 100;
	localparam logic [2:0]  SYNC_RUN_MIN   = 3'h4;   // consecutive sync words before flood acts
	localparam logic [3:0]  RETRY_MAX_DEF  = 4'h3;
	localparam logic [3:0]  RETRY_CAP      = 4'h8;
	localparam logic [31:0] WB_ADDR_CTRL   = 32'h0000_0000;
	localparam logic [31:0] WB_ADDR_ROUTE  = 32'h0000_0004;
	localparam logic [31:0] WB_ADDR_STATUS = 32'h0000_0008;
	localparam logic [31:0] WB_ADDR_EVENT  = 32'h0000_000c;
	localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
	localparam logic [31:0] ROUTE_RST      = 32'h0000_0000;
	localparam logic [31:0] WB_UNMAPPED    = 32'h0000_0000;

	// control register fields
	localparam int C_SERR_EN      = 0;  // command-register system-error enable
	localparam int C_BRIDGE_SERR  = 1;  // bridge-control system-error enable
	localparam int C_RETRY_EN     = 2;  // retry_mode_enable
	localparam int C_IS_BRIDGE    = 3;
	localparam int C_RETRY_MAX_LO = 4;  // 4-bit attempt limit

	// route enables, 3 bits per error: flood, fatal, nonfatal
	localparam int R_PROT = 0;
	localparam int R_OVF  = 3;
	localparam int R_EOC  = 6;
	localparam int R_RESP = 9;
	localparam int R_CRC  = 12;
	localparam int R_SERR = 15;

	typedef struct packed {
		logic [LANES-1:0] data;  // link_data_lanes
		logic             ctl;   // link_control_lane
	} lane_word_t;

	typedef struct packed {
		logic             protocol_error_log;
		logic             overflow_error_log;
		logic             end_chain_error_log;
		logic             inbound_end_chain_log;
		logic             response_error_log;
		logic [3:0]       lane_crc_error_log;
	} err_log_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [31:0] adr;
		logic [31:0] dat;
	} wb_req_t;

	typedef enum logic [2:0] {
		LS_NORMAL = 3'b001,
		LS_RETRY  = 3'b010,
		LS_FLOOD  = 3'b100
	} link_state_t;
endpackage

//--- tb/link_error_flood_retry_control_tb.sv
// self-checking bench for the link flood / retry control block
// assumes two neighbour models on the receive pins and a wishbone master here
`timescale 1ns/10ps
`default_nettype none
module link_error_flood_retry_control_tb;
	import flood_retry_pkg::*;
	logic        clk   = 1'b0;
	logic        rst_b = 1'b0;
	logic        warm  = 1'b0;
	logic        init  = 1'b0;
	logic [1:0]  sync  = 2'b00;
	wb_req_t     wb    = '0;
	err_log_t    err   = '0;
	logic [6:0]  ev    = '0;
	logic        ack;
	logic [31:0] rd, rdat, fo;
	lane_word_t  prx, srx, ptx, stx;
	logic [9:0]  o;
	int          n_fail = 0;
	int          total_checks = 0;
	int          cyc = 0;

	// ------------------------------------------------------------------
	// design, partners, clock, timeout
	// ------------------------------------------------------------------
	flood_retry_ctrl u_dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_warm_rst(warm), .i_wb(wb),
		.o_wb_ack(ack), .o_wb_dat(rdat), .i_pri_rx(prx), .i_sec_rx(srx),
		.i_pri_tx_data(5'h0a), .i_sec_tx_data(5'h15), .o_pri_tx(ptx), .o_sec_tx(stx),
		.i_init_done(init), .i_err_set(err), .i_internal_err(ev[6]), .i_retry_fail(ev[0]),
		.i_retry_ok(ev[1]), .i_pkt_crc_bad(ev[2]), .i_pkt_stomped(ev[3]),
		.i_pkt_is_info(ev[4]), .i_fwd_spec_bad(ev[5]), .i_fwd_crc(32'h1234_5678),
		.o_fwd_crc(fo), .o_crc_gen_en(o[0]), .o_crc_chk_en(o[1]), .o_periodic_crc_en(o[2]),
		.o_retry_mode(o[3]), .o_retry_start(o[4]), .o_pkt_drop(o[5]),
		.o_credit_return(o[6]), .o_spec_allowed(o[7]), .o_fatal(o[8]), .o_nonfatal(o[9]));
	link_partner u_pri (.i_sync(sync[0]), .o_tx(prx));
	link_partner u_sec (.i_sync(sync[1]), .o_tx(srx));

	// core clock
	always #5 clk = ~clk;

	// hang guard, well above the thousand or so cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic ob(input int i, input logic e);
		chk({31'h0, o[i]}, {31'h0, e});
	endtask

	task automatic tx(input logic [4:0] p, input logic [4:0] s);
		chk({22'h0, ptx, stx}, {22'h0, p, s});
	endtask

	// classic single cycle; request held until ack is sampled high
	// only the hang guard ends a wait that never sees ack
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		wb <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rd = rdat;
		wb <= '0;
	endtask

	task automatic st(input int b, input logic e);
		bus(1'b0, WB_ADDR_STATUS, 32'h0);
		chk({31'h0, rd[b]}, {31'h0, e});
	endtask

	// event pulses last one cycle; their effect is looked at in the next one
	task automatic pulse(input logic [6:0] v, input err_log_t e);
		@(posedge clk);
		ev  <= v;
		err <= e;
		@(posedge clk);
		ev  <= '0;
		err <= '0;
		@(negedge clk);
	endtask

	// room for a whole partner word plus synchroniser and sync run count
	task automatic settle();
		repeat (60) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic warm_rst();
		@(posedge clk);
		warm <= 1'b1;
		@(posedge clk);
		warm <= 1'b0;
		@(negedge clk);
	endtask

	// partners fall idle before reset so no stale sync word survives it
	task automatic cold();
		@(posedge clk);
		sync <= 2'b00;
		repeat (20) @(posedge clk);
		rst_b <= 1'b0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		init  <= 1'b1;
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		@(negedge clk);
		chk({22'h0, o}, 32'h7);
		tx(5'h0a, 5'h15);
		bus(1'b0, WB_ADDR_CTRL, 32'h0);
		chk(rd, CTRL_RST);
		bus(1'b0, WB_ADDR_ROUTE, 32'h0);
		chk(rd, ROUTE_RST);
		bus(1'b1, 32'h10, 32'hffff_ffff);
		bus(1'b0, 32'h10, 32'h0);
		chk(rd, WB_UNMAPPED);
		bus(1'b0, WB_ADDR_CTRL, 32'h0);
		chk(rd, CTRL_RST);
	endtask

	task automatic t_relay();
		@(posedge clk);
		init    <= 1'b0;
		sync[0] <= 1'b1;
		settle();
		tx(5'h0a, 5'h15);
		@(posedge clk);
		init <= 1'b1;
		settle();
		tx(5'h1f, 5'h1f);
		ob(0, 1'b0);
		ob(1, 1'b0);
		st(2, 1'b1);
		st(3, 1'b0);
		sync[0] <= 1'b0;
		settle();
		tx(5'h1f, 5'h1f);
		warm_rst();
		tx(5'h0a, 5'h15);
		ob(0, 1'b1);
		st(2, 1'b1);
	endtask

	task automatic t_route();
		cold();
		// protocol: flood and nonfatal; end of chain: fatal only
		bus(1'b1, WB_ADDR_ROUTE, (32'h5 << R_PROT) | (32'h2 << R_EOC));
		pulse(7'h00, 9'h040);
		// log lands one edge after the pulse, the routed level one edge later
		@(negedge clk);
		ob(8, 1'b1);
		ob(9, 1'b0);
		pulse(7'h00, 9'h100);
		settle();
		tx(5'h0a, 5'h15);
		ob(9, 1'b1);
		bus(1'b0, WB_ADDR_EVENT, 32'h0);
		chk(rd, 32'h140);
		bus(1'b1, WB_ADDR_CTRL, 32'h1);
		settle();
		tx(5'h1f, 5'h1f);
		st(3, 1'b1);
		st(4, 1'b0);
		bus(1'b1, WB_ADDR_EVENT, 32'h40);
		bus(1'b0, WB_ADDR_EVENT, 32'h0);
		chk(rd, 32'h100);
		ob(8, 1'b0);
	endtask

	task automatic t_retry();
		cold();
		bus(1'b1, WB_ADDR_CTRL, 32'h34);
		ob(3, 1'b0);
		warm_rst();
		ob(3, 1'b1);
		ob(2, 1'b0);
		ob(7, 1'b1);
		pulse(7'h04, 9'h0);
		chk({29'h0, o[6:4]}, 32'h3);
		pulse(7'h08, 9'h0);
		chk({29'h0, o[6:4]}, 32'h6);
		pulse(7'h20, 9'h0);
		chk(fo, 32'hedcb_a987);
		pulse(7'h30, 9'h0);
		chk(fo, 32'h1234_5678);
		bus(1'b1, WB_ADDR_ROUTE, 32'h1 << (R_CRC + 1));
		pulse(7'h01, 9'h0);
		pulse(7'h02, 9'h0);
		repeat (3) pulse(7'h01, 9'h0);
		st(5, 1'b0);
		pulse(7'h01, 9'h0);
		st(5, 1'b1);
		ob(8, 1'b1);
		bus(1'b1, WB_ADDR_CTRL, 32'h0);
		warm_rst();
		ob(3, 1'b0);
		ob(2, 1'b1);
	endtask

	task automatic t_bridge();
		cold();
		bus(1'b1, WB_ADDR_CTRL, 32'h9);
		bus(1'b1, WB_ADDR_ROUTE, 32'h1 << (R_SERR + 1));
		sync[1] <= 1'b1;
		settle();
		tx(5'h0a, 5'h1f);
		st(4, 1'b1);
		ob(8, 1'b1);
		cold();
		bus(1'b1, WB_ADDR_CTRL, 32'hb);
		sync[1] <= 1'b1;
		settle();
		tx(5'h1f, 5'h1f);
		cold();
		bus(1'b1, WB_ADDR_CTRL, 32'h8);
		sync[0] <= 1'b1;
		settle();
		tx(5'h1f, 5'h1f);
		cold();
		bus(1'b1, WB_ADDR_CTRL, 32'h8);
		pulse(7'h40, 9'h0);
		settle();
		tx(5'h0a, 5'h1f);
		st(4, 1'b0);
	endtask

	// main sequence
	initial begin
		// partners start idle, so the first reset needs no drain time
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		init  <= 1'b1;
		t_reset();
		t_relay();
		t_route();
		t_retry();
		t_bridge();
		wrap_up();
	end
endmodule
`default_nettype wire

//--- tb/link_partner.sv
// neighbour link transmitter model: idle words or a sync flood
// assumes i_sync comes from the bench; words are paced by its own 160 ns link clock
`timescale 1ns/10ps
`default_nettype none
module link_partner
	import flood_retry_pkg::*;
(
	// flood request from the bench
	input  wire logic                        i_sync,
	// lanes toward the block
	output wire flood_retry_pkg::lane_word_t o_tx
);
	// ------------------------------------------------------------------
	// link clock and word pacing
	// ------------------------------------------------------------------
	logic       link_clk = 1'b0;
	lane_word_t word_r   = 5'h01;
	logic [4:0] idle_r   = 5'h01;

	// offset start so link edges never coincide with core clock edges
	initial begin
		#3;
		forever #80 link_clk = ~link_clk;
	end

	// idle word is one-hot and rotates, so it is never a sync word and never stale
	always @(posedge link_clk) begin
		idle_r <= {idle_r[3:0], idle_r[4]};
		word_r <= i_sync ? 5'h1f : idle_r;
	end

	assign o_tx = word_r;
endmodule
`default_nettype wire
